// ---- design/smcg_sleep_ctrl.sv ----
// Sleep mode controller: clock gating, wake-up and analog power control
// Functional notes
// R1: Mode 10 with crystal enters standby
// R2: Standby equals power-down, oscillator kept running
// R3: Standby wake-up completes in six cycles
// R4: Gate core, memory, I/O clocks per mode
// R5: Deep sleep wakes only from pin sources
// R6: Comparator off in all non-idle sleep
// R7: Comparator reference need keeps reference on
// R8: Enabled brown-out detector survives all sleep
// R9: Enabled watchdog runs in every mode
// R10: Reference on only when something needs it
// R11: Software waits reference start-up after enable
// R12: Input buffers off while I/O clock stopped
// R13: Wake source pin buffers stay enabled
// R14: Disable bit forces pin buffer off
// R15: Select 00 idle, 01/11 down, 10 standby
// R16: Sleep only when sleep gate set
// R17: Four stall cycles, handler, then resume
// R18: Sleep with gate clear is no-op
`timescale 1ns/1ps
`default_nettype none
module smcg_sleep_ctrl import smcg_pkg::*; #(
  parameter int NPINS = 8,
  parameter int STARTUP_CYC = SMCG_STARTUP_CYC
) (
  input wire logic clk,                       // System clock, 50 MHz
  input wire logic rst_n,                     // Async reset, active low
  input wire logic sleep_exec,                // Core executes sleep, pulse
  input wire logic sleep_gate_bit,            // Sleep permitted
  input wire logic [1:0] sleep_mode_select,   // Mode select field
  input wire logic xtal_clock_sel,            // Crystal clock option chosen
  input wire smcg_pin_wake_t pin_wake,        // Pin wake requests, async
  input wire logic ext_irq_a_level,           // First ext irq in level mode
  input wire logic self_program_store_rdy,    // Store or EEPROM ready irq
  input wire logic other_io_irq,              // Any other internal irq
  input wire logic comp_disable,              // Comparator disabled by sw
  input wire logic comp_uses_ref,             // Comparator uses reference
  input wire logic [2:0] brownout_level_fuse, // Brown-out level fuses
  input wire logic wdt_enable,                // Watchdog enabled
  input wire logic [NPINS-1:0] digital_input_disable, // Per-pin disable
  input wire logic [NPINS-1:0] wake_pin_mask, // Pins used as wake sources
  output smcg_clk_en_t clk_en,                // Clock domain enables
  output logic comparator_en,                 // Comparator powered
  output logic brownout_detector_en,          // Brown-out detector on
  output logic vref_en,                       // Internal reference on
  output logic wdt_run,                       // Watchdog clock running
  output logic [NPINS-1:0] input_buf_en,      // Pin input buffers
  output logic sleeping,                      // Device in sleep or wake
  output logic core_stall,                    // Core held after wake
  output logic handler_go                     // Run handler, pulse
);
  smcg_state_t state_reg;
  smcg_state_t state_next;
  smcg_mode_t mode_reg;
  smcg_mode_t mode_next;
  smcg_mode_t sel_mode;
  logic [SMCG_CNT_W-1:0] cnt_reg;
  logic [SMCG_CNT_W-1:0] cnt_next;
  smcg_pin_wake_t pin_sync;
  smcg_clk_en_t clk_en_next;
  logic deep_wake;
  logic any_wake;
  logic wake_hit;
  logic sleep_req;
  logic asleep_next;
  logic deep_next;
  logic bod_need;
  logic cmp_ref_need;

  localparam logic [SMCG_CNT_W-1:0] STBY_LOAD =
    SMCG_CNT_W'(SMCG_STBY_WAKE_CYC - 2);
  localparam logic [SMCG_CNT_W-1:0] PDOWN_LOAD =
    SMCG_CNT_W'(STARTUP_CYC - 2);
  localparam logic [SMCG_CNT_W-1:0] STALL_LOAD =
    SMCG_CNT_W'(SMCG_STALL_CYC - 1);

  // Pin wake sources cross into the clock domain
  smcg_sync3 #(.WIDTH(4)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(pin_wake),
    .dout(pin_sync)
  );

  // R15: select decode; R1: standby needs crystal
  assign sel_mode = (sleep_mode_select == SMCG_SEL_IDLE) ? SMCG_MODE_IDLE :
    (sleep_mode_select == SMCG_SEL_STBY && xtal_clock_sel) ? SMCG_MODE_STBY :
    SMCG_MODE_PDOWN;

  // R5: deep sleep wake set; first ext irq only in level mode
  assign deep_wake = (pin_sync.ext_irq_a && ext_irq_a_level) ||
    pin_sync.ext_irq_b || pin_sync.pin_change || pin_sync.usi_start;
  assign any_wake = pin_sync.ext_irq_a || deep_wake ||
    self_program_store_rdy || other_io_irq;
  assign wake_hit = (mode_reg == SMCG_MODE_IDLE) ? any_wake : deep_wake;
  // R16: entry qualified by gate; R18: otherwise a no-op
  assign sleep_req = sleep_exec && sleep_gate_bit;

  // Sequencer: run, sleep, clock restart, post-wake stall
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      SMCG_ST_RUN: begin
        if (sleep_req) begin
          state_next = SMCG_ST_SLEEP;
          mode_next = sel_mode;
        end
      end
      SMCG_ST_SLEEP: begin
        if (wake_hit) begin
          if (mode_reg == SMCG_MODE_IDLE) begin
            state_next = SMCG_ST_STALL;
            cnt_next = STALL_LOAD;
          end else begin
            // R3: standby short fixed restart; power-down waits STARTUP_CYC
            state_next = SMCG_ST_WAKE;
            cnt_next = (mode_reg == SMCG_MODE_STBY) ? STBY_LOAD : PDOWN_LOAD;
          end
        end
      end
      SMCG_ST_WAKE: begin
        if (cnt_reg == '0) begin
          state_next = SMCG_ST_STALL;
          cnt_next = STALL_LOAD;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      SMCG_ST_STALL: begin
        // R17: hold core four cycles, then handler
        if (cnt_reg == '0) begin
          state_next = SMCG_ST_RUN;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: state_next = SMCG_ST_RUN;
    endcase
  end

  assign asleep_next = (state_next == SMCG_ST_SLEEP) ||
    (state_next == SMCG_ST_WAKE);
  assign deep_next = asleep_next && (mode_next != SMCG_MODE_IDLE);

  // R4: per-mode clock gating; R2: standby keeps oscillator
  assign clk_en_next.core_clock_domain = !asleep_next;
  assign clk_en_next.program_memory_clock = !asleep_next;
  assign clk_en_next.peripheral_io_clock = !deep_next;
  assign clk_en_next.oscillator = !((state_next == SMCG_ST_SLEEP) &&
    (mode_next == SMCG_MODE_PDOWN));

  // R8: fuse alone decides, sleep never gates it
  assign bod_need = brownout_level_fuse != SMCG_BOD_OFF_CODE;
  // R7: comparator reference need survives sleep
  assign cmp_ref_need = !comp_disable && comp_uses_ref;

  // State and mode registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SMCG_ST_RUN;
      mode_reg <= SMCG_MODE_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
    end
  end

  // Registered outputs follow next state so they match state_reg
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_en <= '1;
      comparator_en <= 1'b0;
      brownout_detector_en <= 1'b0;
      vref_en <= 1'b0;
      wdt_run <= 1'b0;
      sleeping <= 1'b0;
      core_stall <= 1'b0;
      handler_go <= 1'b0;
    end else begin
      clk_en <= clk_en_next;
      // R6: comparator forced off in deep sleep
      comparator_en <= !comp_disable && !deep_next;
      brownout_detector_en <= bod_need;
      // R10: reference only while a consumer needs it
      vref_en <= bod_need || cmp_ref_need;
      // R9: watchdog ignores sleep mode
      wdt_run <= wdt_enable;
      sleeping <= asleep_next;
      core_stall <= state_next == SMCG_ST_STALL;
      handler_go <= (state_reg == SMCG_ST_STALL) &&
        (state_next == SMCG_ST_RUN);
    end
  end

  // Pin input buffers; floating inputs in sleep would waste power
  genvar p;
  generate
    for (p = 0; p < NPINS; p = p + 1) begin : g_pin
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          input_buf_en[p] <= 1'b0;
        end else begin
          // R14: disable bit wins; R12 off when I/O stopped; R13 wake pins
          input_buf_en[p] <= !digital_input_disable[p] &&
            (clk_en_next.peripheral_io_clock || wake_pin_mask[p]);
        end
      end
    end
  endgenerate

  property p_gate_nop;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == SMCG_ST_RUN && sleep_exec && !sleep_gate_bit)
      |=> (state_reg == SMCG_ST_RUN && clk_en.core_clock_domain);
  endproperty
  a_gate_nop: assert property (p_gate_nop) // R18
    else $error("sleep entered with gate clear");

  property p_entry;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == SMCG_ST_RUN && sleep_exec && sleep_gate_bit)
      |=> (state_reg == SMCG_ST_SLEEP && !clk_en.core_clock_domain);
  endproperty
  a_entry: assert property (p_entry) // R16
    else $error("gated sleep not entered");

  property p_idle_clk;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == SMCG_ST_SLEEP && mode_reg == SMCG_MODE_IDLE)
      |-> (!clk_en.core_clock_domain && !clk_en.program_memory_clock &&
           clk_en.peripheral_io_clock && clk_en.oscillator);
  endproperty
  a_idle_clk: assert property (p_idle_clk) // R4
    else $error("idle clock gating wrong");

  property p_pdown_clk;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == SMCG_ST_SLEEP && mode_reg == SMCG_MODE_PDOWN)
      |-> (!clk_en.oscillator && !clk_en.peripheral_io_clock);
  endproperty
  a_pdown_clk: assert property (p_pdown_clk) // R4
    else $error("power-down clocks not stopped");

  property p_stby_osc;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == SMCG_ST_SLEEP && mode_reg == SMCG_MODE_STBY)
      |-> (clk_en.oscillator && !clk_en.peripheral_io_clock);
  endproperty
  a_stby_osc: assert property (p_stby_osc) // R2
    else $error("standby oscillator state wrong");

  property p_stby_wake;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == SMCG_ST_SLEEP && mode_reg == SMCG_MODE_STBY && wake_hit)
      |=> !clk_en.core_clock_domain [*5] ##1 clk_en.core_clock_domain;
  endproperty
  a_stby_wake: assert property (p_stby_wake) // R3
    else $error("standby wake not six cycles");

  property p_stall;
    @(posedge clk) disable iff (!rst_n)
    $rose(core_stall) |-> core_stall [*4] ##1 (handler_go && !core_stall);
  endproperty
  a_stall: assert property (p_stall) // R17
    else $error("post-wake stall length wrong");

  property p_deep_wake;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == SMCG_ST_SLEEP && mode_reg != SMCG_MODE_IDLE && !deep_wake)
      |=> state_reg == SMCG_ST_SLEEP;
  endproperty
  a_deep_wake: assert property (p_deep_wake) // R5
    else $error("deep sleep woken by wrong source");

  property p_comp_off;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == SMCG_ST_SLEEP && mode_reg != SMCG_MODE_IDLE)
      |-> !comparator_en;
  endproperty
  a_comp_off: assert property (p_comp_off) // R6
    else $error("comparator on in deep sleep");

  property p_vref;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> vref_en ==
      (($past(brownout_level_fuse) != SMCG_BOD_OFF_CODE) ||
       ($past(comp_uses_ref) && !$past(comp_disable)));
  endproperty
  a_vref: assert property (p_vref) // R10
    else $error("reference enable mismatch");

  property p_bod;
    @(posedge clk) disable iff (!rst_n)
    (brownout_level_fuse != SMCG_BOD_OFF_CODE) |=> brownout_detector_en;
  endproperty
  a_bod: assert property (p_bod) // R8
    else $error("brown-out detector gated off");

  property p_wdt;
    @(posedge clk) disable iff (!rst_n)
    wdt_enable |=> wdt_run;
  endproperty
  a_wdt: assert property (p_wdt) // R9
    else $error("watchdog stopped while enabled");

  property p_digital_input_disable;
    @(posedge clk) disable iff (!rst_n)
    digital_input_disable[0] |=> !input_buf_en[0];
  endproperty
  a_digital_input_disable: assert property (p_digital_input_disable) // R14
    else $error("disabled pin buffer still on");
endmodule : smcg_sleep_ctrl
`default_nettype wire

// ---- include/smcg_pkg.sv ----
// Shared constants and types for the sleep and clock gating controller
package smcg_pkg;
  // Sleep mode select encodings
  localparam logic [1:0] SMCG_SEL_IDLE = 2'h0;
  localparam logic [1:0] SMCG_SEL_PDOWN_A = 2'h1;
  localparam logic [1:0] SMCG_SEL_STBY = 2'h2;
  localparam logic [1:0] SMCG_SEL_PDOWN_B = 2'h3;
  // Brown-out fuse code that switches the detector off
  localparam logic [2:0] SMCG_BOD_OFF_CODE = 3'h7;
  // Wake timing in system clock cycles; counter width in bits
  localparam int SMCG_STBY_WAKE_CYC = 6;
  localparam int SMCG_STALL_CYC = 4;
  localparam int SMCG_STARTUP_CYC = 64;
  localparam int SMCG_CNT_W = 16;
  // Synchroniser depth for pin inputs
  localparam int SMCG_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    SMCG_MODE_IDLE,
    SMCG_MODE_PDOWN,
    SMCG_MODE_STBY
  } smcg_mode_t;

  typedef enum logic [1:0] {
    SMCG_ST_RUN,
    SMCG_ST_SLEEP,
    SMCG_ST_WAKE,
    SMCG_ST_STALL
  } smcg_state_t;

  // Asynchronous wake requests arriving on pins
  typedef struct packed {
    logic ext_irq_a;
    logic ext_irq_b;
    logic pin_change;
    logic usi_start;
  } smcg_pin_wake_t;

  // Clock domain enables
  typedef struct packed {
    logic core_clock_domain;
    logic program_memory_clock;
    logic peripheral_io_clock;
    logic oscillator;
  } smcg_clk_en_t;
endpackage : smcg_pkg

// ---- design/smcg_sync3.sv ----
// Three-stage pin synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
`default_nettype none
module smcg_sync3 import smcg_pkg::*; #(
  parameter int WIDTH = 4
) (
  input wire logic clk,              // System clock
  input wire logic rst_n,            // Async reset, active low
  input wire logic [WIDTH-1:0] din,  // Asynchronous inputs
  output logic [WIDTH-1:0] dout      // Filtered synchronous level
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic out_reg;
      // First stage feeds only the second; level accepted when 2 and 3 agree
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          out_reg <= 1'b0;
        end else begin
          s1_reg <= din[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign dout[i] = out_reg;
    end
  endgenerate
endmodule : smcg_sync3
`default_nettype wire

// ---- test/smcg_core_model.sv ----
// Behavioural core model that issues the sleep instruction
`timescale 1ns/1ps
`default_nettype none
module smcg_core_model import smcg_pkg::*; (
  input wire logic clk,        // System clock
  input wire logic rst_n,      // Async reset, active low
  input wire logic req,        // Bench asks for one sleep
  input wire logic no_gate,    // Leave the sleep gate clear
  input wire logic handler_go, // Wake handler start
  output logic sleep_exec,     // Sleep instruction pulse
  output logic sleep_gate_bit  // Sleep permitted
);
  logic [1:0] ph_reg;
  // Changes on the rising edge by nonblocking, so the block sees it cleanly
  // gate set before sleep
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_reg <= 2'h0;
      sleep_exec <= 1'b0;
      sleep_gate_bit <= 1'b0;
    end else begin
      sleep_exec <= 1'b0;
      case (ph_reg)
        2'h0: if (req) begin
          sleep_gate_bit <= !no_gate;
          ph_reg <= 2'h1;
        end
        2'h1: begin
          sleep_exec <= 1'b1;
          ph_reg <= 2'h2;
        end
        default: if (handler_go || !sleep_gate_bit) begin
          sleep_gate_bit <= 1'b0;
          ph_reg <= 2'h0;
        end
      endcase
    end
  end
endmodule : smcg_core_model
`default_nettype wire

// ---- test/sleep_mode_clock_gating_test.sv ----
// Self-checking bench for the sleep and clock gating controller
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_clock_gating_test;
  import smcg_pkg::*;
  // Short restart keeps the run brief; latencies derive from it
  localparam int STUP = 12;
  typedef struct {
    smcg_clk_en_t ce;
    logic cmp, vref, brownout_detector, wdt;
    logic [7:0] bufs;
    int lo, hi;
  } smcg_note_t;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, no_gate = 1'b0;
  logic sleep_exec, sleep_gate_bit, xtal = 1'b0, a_lvl = 1'b0;
  logic self_program_store = 1'b0, oio = 1'b0, cdis = 1'b0, cref = 1'b0, wdt_en = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [2:0] fuse = 3'h7;
  logic [7:0] dis = 8'h00, mask = 8'h00, ibuf, cap_buf;
  smcg_pin_wake_t pw = '0;
  smcg_clk_en_t clk_en, cap_ce;
  logic cmp_en, bod_en, vref_en, wdt_run, sleeping, core_stall, handler_go;
  logic cap_cmp, cap_vref, cap_bod, cap_wdt, slp_q, core_q;
  logic stby_alt = 1'b0;
  int cyc = 0, wake_t = 0, lat = 0, nst = 0, miscompares = 0, n_checks = 0;
  smcg_note_t q[$];
  smcg_note_t n;

  initial forever #10 clk = ~clk;

  smcg_sleep_ctrl #(.NPINS(8), .STARTUP_CYC(STUP)) DUT (
    .clk(clk), .rst_n(rst_n), .sleep_exec(sleep_exec),
    .sleep_gate_bit(sleep_gate_bit), .sleep_mode_select(sel),
    .xtal_clock_sel(xtal), .pin_wake(pw), .ext_irq_a_level(a_lvl),
    .self_program_store_rdy(self_program_store), .other_io_irq(oio),
    .comp_disable(cdis), .comp_uses_ref(cref),
    .brownout_level_fuse(fuse), .wdt_enable(wdt_en),
    .digital_input_disable(dis), .wake_pin_mask(mask), .clk_en(clk_en),
    .comparator_en(cmp_en), .brownout_detector_en(bod_en),
    .vref_en(vref_en), .wdt_run(wdt_run), .input_buf_en(ibuf),
    .sleeping(sleeping), .core_stall(core_stall), .handler_go(handler_go));

  smcg_core_model core (.clk(clk), .rst_n(rst_n), .req(req),
    .no_gate(no_gate), .handler_go(handler_go), .sleep_exec(sleep_exec),
    .sleep_gate_bit(sleep_gate_bit));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD t=%0t %s", $time, m);
    end
  endtask : check

  task automatic check_static();
    check(bod_en === (fuse != 3'h7), "detector enable");
    check(vref_en === ((fuse != 3'h7) || (!cdis && cref)), "vref");
    check(wdt_run === wdt_en, "watchdog run");
    check(cmp_en === !cdis, "comparator awake");
    check(ibuf === ~dis, "input buffers awake");
  endtask : check_static

  // Cycle count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      $display("BAD t=%0t run timed out", $time);
      complete_run();
    end
  end

  // Watches outputs; each handler start retires the oldest note
  always @(negedge clk) begin
    if (rst_n) begin
      if (sleeping === 1'b1 && slp_q !== 1'b1) begin
        cap_ce = clk_en;
        cap_cmp = cmp_en;
        cap_buf = ibuf;
        cap_vref = vref_en;
        cap_bod = bod_en;
        cap_wdt = wdt_run;
      end
      if (core_q === 1'b0 && clk_en.core_clock_domain === 1'b1) lat = cyc - wake_t;
      if (core_stall === 1'b1) nst++;
      if (handler_go === 1'b1) begin
        check(q.size() > 0, "unexpected handler start");
        if (q.size() > 0) begin
          n = q.pop_front();
          check(cap_ce === n.ce, "clock enables in sleep");
          check(cap_cmp === n.cmp, "comparator in sleep");
          check(cap_buf === n.bufs, "buffers in sleep");
          check(cap_vref === n.vref, "vref in sleep");
          check(cap_bod === n.brownout_detector && cap_wdt === n.wdt, "bod wdt");
          check(lat >= n.lo && lat <= n.hi, "wake latency");
          check(nst == SMCG_STALL_CYC, "stall length");
        end
        nst = 0;
      end
      slp_q = sleeping;
      core_q = clk_en.core_clock_domain;
    end
  end

  task automatic sleep_once(input logic [1:0] m);
    smcg_note_t e;
    logic deep, stby;
    int k;
    @(negedge clk);
    sel = m;
    // alternate crystal so standby and its fallback both occur
    if (m == SMCG_SEL_STBY) begin
      stby_alt = !stby_alt;
    end
    xtal = (m == SMCG_SEL_STBY) ? stby_alt : 1'($urandom_range(1));
    cdis = 1'($urandom_range(1));
    cref = 1'($urandom_range(1));
    wdt_en = 1'($urandom_range(1));
    fuse = $urandom_range(1) ? 3'h7 : 3'($urandom);
    dis = 8'($urandom);
    mask = 8'($urandom);
    // reference settles before anything relies on it
    repeat (2) @(negedge clk);
    deep = (m != SMCG_SEL_IDLE);
    stby = (m == SMCG_SEL_STBY) && xtal;
    e.ce = '{1'b0, 1'b0, !deep, !deep || stby};
    e.cmp = !deep && !cdis;
    e.bufs = ~dis & (deep ? mask : 8'hFF);
    e.vref = (fuse != 3'h7) || (!cdis && cref);
    e.brownout_detector = (fuse != 3'h7);
    e.wdt = wdt_en;
    e.lo = deep ? (stby ? 8 : STUP + 2) : 1;
    e.hi = deep ? (stby ? 12 : STUP + 6) : 3;
    q.push_back(e);
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    repeat (4) @(negedge clk);
    // Deep sleep: offer the sources that must not wake it first
    if (deep) begin
      oio = 1'b1;
      self_program_store = 1'b1;
      pw.ext_irq_a = 1'b1;
      repeat (10) @(negedge clk);
      check(sleeping === 1'b1 && clk_en.core_clock_domain === 1'b0,
        "woke from refused source");
      oio = 1'b0;
      self_program_store = 1'b0;
      pw = '0;
      repeat (6) @(negedge clk);
      a_lvl = 1'b1;
      pw = smcg_pin_wake_t'(4'(4'h8 >> $urandom_range(3)));
    end else if ($urandom_range(1)) oio = 1'b1;
    else self_program_store = 1'b1;
    wake_t = cyc;
    k = 0;
    while (handler_go !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    check(k < 200, "no handler start");
    oio = 1'b0;
    self_program_store = 1'b0;
    pw = '0;
    a_lvl = 1'b0;
    repeat (8) @(negedge clk);
    check_static();
    $display("test sleep select %0d done", m);
  endtask : sleep_once

  initial begin
    void'($urandom(32'hC4663E16));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check_static();
    no_gate = 1'b1;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    repeat (6) @(negedge clk);
    check(sleeping === 1'b0 && clk_en === 4'hF, "sleep with gate clear");
    no_gate = 1'b0;
    $display("test gate clear done");
    for (int i = 0; i < 16; i++) begin
      sleep_once(2'(i));
    end
    // reset taken in sleep brings everything back to run
    sel = SMCG_SEL_PDOWN_A;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    repeat (4) @(negedge clk);
    check(sleeping === 1'b1, "not asleep before reset");
    rst_n = 1'b0;
    @(negedge clk);
    check(sleeping === 1'b0 && clk_en === 4'hF, "outputs in reset");
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check(sleeping === 1'b0 && core_stall === 1'b0, "resume after reset");
    check_static();
    check(q.size() == 0, "expected results left over");
    $display("test reset in sleep done");
    complete_run();
  end
endmodule : sleep_mode_clock_gating_test
`default_nettype wire
